// File: inc/core_cfg.svh
/*
  Encodings, register addresses, field positions and reset values for the execution core.
  Assumes it is included by its bare name wherever these names are needed.
*/
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// -----------------------------------------------------------
// instruction cycle
// -----------------------------------------------------------
`define PH_LAST 2'h3
`define PH_ONE 2'h1

// -----------------------------------------------------------
// opcode fields
// -----------------------------------------------------------
`define OPC_ADD_F 6'h07
`define OPC_AND_F 6'h05
`define OPC_COPY_F 6'h08
`define OPN_AND_IMM 4'hE
`define OPG_BRANCH 3'h5
`define OPT_DIR_HI 9'h000
`define NOP_WORD 12'h000

// -----------------------------------------------------------
// file register addresses
// -----------------------------------------------------------
`define A_TIMER 5'h01
`define A_PCL 5'h02
`define A_STATUS 5'h03
`define A_PORT0 5'h05
`define A_PORT1 5'h06
`define A_PORT2 5'h07
`define DIR_BASE 3'h5

// -----------------------------------------------------------
// status bit positions
// -----------------------------------------------------------
`define ST_C 0
`define ST_DIG_CARRY 1
`define ST_Z 2

// -----------------------------------------------------------
// reset values
// -----------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_DIR 8'hFF
`define RST_PC 9'h000
`define PC_ONE 9'h001

`endif

// File: inc/core_pkg.sv
/*
  Types shared by the execution core and its arithmetic unit.
  Assumes it is compiled before every interface and module.
*/
package core_pkg;

	// operation selected for the arithmetic unit
	typedef enum logic [1:0] {
		alu_add = 2'b00,
		alu_and = 2'b01,
		alu_pass = 2'b10
	} alu_op_t;

	typedef logic [7:0] byte_t;

endpackage

// File: inc/alu_if.sv
/*
  Interface joining the execution core to its arithmetic unit.
  Assumes core_pkg is compiled first; purely combinational signals.
*/
`timescale 1ns/10ps

interface alu_if;
	import core_pkg::*;
	alu_op_t op;
	byte_t a;
	byte_t b;
	byte_t y;
	logic c;
	logic digit_carry_flag;
	logic z;

	modport core (output op, output a, output b, input y, input c, input digit_carry_flag,
		input z);
	modport alu (input op, input a, input b, output y, output c, output digit_carry_flag,
		output z);
endinterface

// File: logic/alu_unit.sv
/*
  Eight-bit arithmetic unit: add with carry and digit carry, bitwise and, pass-through.
  Assumes operands are stable within the instruction cycle; no clock of its own.
*/
`timescale 1ns/10ps

module alu_unit
	import core_pkg::*;
(
	alu_if.alu bus
);

	logic [8:0] sum9;
	logic [4:0] nib5;

	// -----------------------------------------------------------
	// result and flags
	// -----------------------------------------------------------
	// carries come from widened sums so no bit is dropped silently
	always_comb begin
		sum9 = {1'b0, bus.a} + {1'b0, bus.b};
		nib5 = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
		bus.c = 1'b0;
		bus.digit_carry_flag = 1'b0;
		unique case (bus.op)
			alu_add: begin
				bus.y = sum9[7:0];
				bus.c = sum9[8];
				bus.digit_carry_flag = nib5[4];
			end
			alu_and: begin
				bus.y = bus.a & bus.b;
			end
			alu_pass: begin
				bus.y = bus.b;
			end
			default: begin
				bus.y = bus.b;
			end
		endcase
		bus.z = (bus.y == 8'h00);
	end

endmodule

// File: logic/core_exec.sv
/*
  Execution core for a subset of an eight-bit accumulator instruction set, with file
  registers, three ports with direction latches and a timer prescaler clear strobe.
  Assumes program memory answers prog_addr combinationally on prog_data and that all
  inputs are synchronous to mclk, which is the oscillator.
*/
// What this block does
// - program counter writes clear its ninth bit, except the unconditional branch
// - read-modify-write of a port uses pin levels, not output latches
// - direction load with operand 5, 6, 7 copies accumulator to port 0/1/2
// - a direction bit of one turns that pin's output driver off
// - writing the timer with destination one clears prescaler when assigned to it
// - opcode 000111df: add accumulator and file register, result to destination
// - opcode 000101df: and accumulator with file register, result to destination
// - destination bit zero writes accumulator, one writes the file register back
// - top nibble 1110: and accumulator with immediate byte into accumulator
// - instruction cycle is four clocks; program counter changes take two cycles
`timescale 1ns/10ps
`include "core_cfg.svh"

module core_exec
	import core_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	output logic [8:0] prog_addr,
	input wire logic [11:0] prog_data,
	input wire logic [2:0][7:0] port_in,
	output logic [2:0][7:0] port_out,
	output logic [2:0][7:0] port_oe,
	input wire logic presc_on_timer,
	output logic presc_clear,
	output logic [7:0] acc_out,
	output logic [7:0] status_out,
	output logic cycle_end
);

	// -----------------------------------------------------------
	// reset release
	// -----------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// -----------------------------------------------------------
	// state
	// -----------------------------------------------------------
	logic [1:0] ph_q, ph_d;
	logic [11:0] ir_q, ir_d;
	logic [8:0] pc_q, pc_d;
	byte_t w_q, w_d, stat_q, stat_d, tmr_q, tmr_d;
	logic [2:0][7:0] latch_q, latch_d, dir_q, dir_d;
	logic presc_q, presc_d;
	byte_t gpr [0:31];

	logic exec;
	logic [4:0] f;
	logic dbit;
	logic is_add, is_andf, is_copy, is_andl, uncond_branch_op, is_dir, fop, wr_file, wr_w;
	logic branch;
	logic [1:0] dir_idx;
	logic [2:0] dir_off;
	byte_t file_rd;

	alu_if abus ();

	alu_unit u_alu (
		.bus(abus)
	);

	// -----------------------------------------------------------
	// decode
	// -----------------------------------------------------------
	// execute on the last of four oscillator phases
	assign exec = (ph_q == `PH_LAST);
	assign f = ir_q[4:0];
	assign dbit = ir_q[5];
	assign is_add = (ir_q[11:6] == `OPC_ADD_F);
	assign is_andf = (ir_q[11:6] == `OPC_AND_F);
	assign is_copy = (ir_q[11:6] == `OPC_COPY_F);
	assign is_andl = (ir_q[11:8] == `OPN_AND_IMM);
	assign uncond_branch_op = (ir_q[11:9] == `OPG_BRANCH);
	// only operands 5..7 act; lower codes are other control words
	assign is_dir = (ir_q[11:3] == `OPT_DIR_HI) && (f[2:0] >= `DIR_BASE);
	assign dir_off = f[2:0] - `DIR_BASE;
	assign dir_idx = dir_off[1:0];
	assign fop = is_add | is_andf | is_copy;
	assign wr_file = fop & dbit;
	assign wr_w = (fop & ~dbit) | is_andl;
	assign branch = uncond_branch_op | (wr_file && (f == `A_PCL));

	// file read; ports return pin levels so read-modify-write sees the pins
	always_comb begin
		unique case (f)
			`A_TIMER: file_rd = tmr_q;
			`A_PCL: file_rd = pc_q[7:0];
			`A_STATUS: file_rd = stat_q;
			`A_PORT0: file_rd = port_in[0];
			`A_PORT1: file_rd = port_in[1];
			`A_PORT2: file_rd = port_in[2];
			default: file_rd = gpr[f];
		endcase
	end

	// operand routing to the arithmetic unit
	always_comb begin
		abus.a = w_q;
		abus.b = is_andl ? ir_q[7:0] : file_rd;
		if (is_add) begin
			abus.op = alu_add;
		end else if (is_andf | is_andl) begin
			abus.op = alu_and;
		end else begin
			abus.op = alu_pass;
		end
	end

	// -----------------------------------------------------------
	// next state
	// -----------------------------------------------------------
	always_comb begin
		ph_d = ph_q + `PH_ONE;
		ir_d = ir_q;
		pc_d = pc_q;
		w_d = w_q;
		stat_d = stat_q;
		tmr_d = tmr_q;
		latch_d = latch_q;
		dir_d = dir_q;
		presc_d = 1'b0;
		if (exec) begin
			pc_d = pc_q + `PC_ONE;
			// the word fetched under a branch is dropped, giving two cycles
			ir_d = branch ? `NOP_WORD : prog_data;
			if (wr_w) begin
				w_d = abus.y;
			end
			if (wr_file) begin
				unique case (f)
					`A_TIMER: tmr_d = abus.y;
					`A_PCL: pc_d = {1'b0, abus.y};
					`A_STATUS: stat_d = abus.y;
					`A_PORT0: latch_d[0] = abus.y;
					`A_PORT1: latch_d[1] = abus.y;
					`A_PORT2: latch_d[2] = abus.y;
					default: ;
				endcase
			end
			// prescaler is cleared only while it serves the timer
			presc_d = wr_file && (f == `A_TIMER) && presc_on_timer;
			if (uncond_branch_op) begin
				pc_d = ir_q[8:0];
			end
			if (is_dir) begin
				dir_d[dir_idx] = w_q;
			end
			// flags applied after a status write so they win
			if (fop | is_andl) begin
				stat_d[`ST_Z] = abus.z;
			end
			if (is_add) begin
				stat_d[`ST_C] = abus.c;
				stat_d[`ST_DIG_CARRY] = abus.digit_carry_flag;
			end
		end
	end

	// -----------------------------------------------------------
	// registers
	// -----------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= 2'h0;
			ir_q <= `NOP_WORD;
			pc_q <= `RST_PC;
			w_q <= `RST_BYTE;
			stat_q <= `RST_BYTE;
			tmr_q <= `RST_BYTE;
			latch_q <= {3{`RST_BYTE}};
			dir_q <= {3{`RST_DIR}};
			presc_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			ir_q <= ir_d;
			pc_q <= pc_d;
			w_q <= w_d;
			stat_q <= stat_d;
			tmr_q <= tmr_d;
			latch_q <= latch_d;
			dir_q <= dir_d;
			presc_q <= presc_d;
		end
	end

	// general registers hold data only, so no reset is spent on them
	always_ff @(posedge mclk) begin
		if (exec && wr_file && (f > `A_PORT2)) begin
			gpr[f] <= abus.y;
		end
	end

	// -----------------------------------------------------------
	// outputs
	// -----------------------------------------------------------
	assign prog_addr = pc_q;
	assign port_out = latch_q;
	assign port_oe = ~dir_q;
	assign presc_clear = presc_q;
	assign acc_out = w_q;
	assign status_out = stat_q;
	assign cycle_end = exec;

	// -----------------------------------------------------------
	// checks
	// -----------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_branch;
		exec && branch;
	endsequence
	sequence s_flushed;
		(ir_q == `NOP_WORD) [*4];
	endsequence

	a_cycle_len: assert property (exec |=> !exec [*3] ##1 exec)
		else $error("instruction cycle is not four clocks");
	a_branch_flush: assert property (s_branch |=> s_flushed)
		else $error("word after branch not discarded");
	a_jump_target: assert property (exec && uncond_branch_op
		|=> pc_q == $past(ir_q[8:0]))
		else $error("branch target wrong");
	a_pcl_bit8: assert property (exec && !uncond_branch_op && wr_file && f == `A_PCL
		|=> !pc_q[8])
		else $error("ninth counter bit not cleared");
	a_port_pins: assert property (exec && is_copy && dbit && f == `A_PORT0
		|=> port_out[0] == $past(port_in[0]))
		else $error("port write-back did not use pins");
	a_dir_load: assert property (exec && is_dir
		|=> port_oe[$past(dir_idx)] == ~$past(w_q))
		else $error("direction load or driver enable wrong");
	a_dir_hold: assert property (!(exec && is_dir) |=> port_oe == $past(port_oe))
		else $error("driver enable changed without direction load");
	a_presc_clr: assert property (exec && wr_file && f == `A_TIMER && presc_on_timer
		|=> presc_clear ##1 !presc_clear)
		else $error("prescaler clear pulse wrong");
	a_add_acc: assert property (exec && is_add && !dbit
		|=> w_q == $past(w_q) + $past(file_rd))
		else $error("add result wrong");
	a_andf_dest: assert property (exec && is_andf && dbit |=> w_q == $past(w_q))
		else $error("accumulator changed on file destination");
	a_and_imm: assert property (exec && is_andl
		|=> w_q == ($past(w_q) & $past(ir_q[7:0])))
		else $error("immediate and wrong");
	a_and_flags: assert property (exec && (is_andl || is_andf) && f != `A_STATUS
		|=> status_out[1:0] == $past(stat_q[1:0]))
		else $error("and changed carry flags");

endmodule

// File: tb/pad_and_rom_model.sv
/*
  Far side of the core: program memory read by address, and the pads of three ports.
  Assumes the bench fills rom before reset is released and drives the outside levels.
*/
`timescale 1ns/10ps

module pad_and_rom_model (
	input wire logic [8:0] prog_addr,
	output logic [11:0] prog_data,
	input wire logic [2:0][7:0] port_out,
	input wire logic [2:0][7:0] port_oe,
	input wire logic [2:0][7:0] ext_level,
	output logic [2:0][7:0] port_in
);
	// -----------------------------------------------------------
	// memory and pads
	// -----------------------------------------------------------
	logic [11:0] rom [0:511];

	// words answer at once; a pad shows its latch only while its driver is on
	assign prog_data = rom[prog_addr];
	assign port_in = (port_oe & port_out) | (~port_oe & ext_level);
endmodule

// File: tb/accum_cpu_alu_op_subset_tb_top.sv
/*
  Self-checking bench for core_exec: runs a short program, models each execute edge.
  Assumes core_pkg is compiled first; the design asserts its own timing rules.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end

module accum_cpu_alu_op_subset_tb_top;
	typedef struct packed {
		logic [7:0] acc; logic [7:0] st; logic [2:0][7:0] po; logic [2:0][7:0] oe;
		logic [8:0] pc; logic presc; logic stk;
	} expect_t;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic presc_on_timer = 1'b0;
	logic [2:0][7:0] ext_level = '0;
	logic [8:0] prog_addr;
	logic [11:0] prog_data;
	logic [2:0][7:0] port_in, port_out, port_oe;
	logic presc_clear, cycle_end;
	logic [7:0] acc_out, status_out;
	int n_mismatch = 0;
	int comparisons = 0;
	expect_t notes[$];
	logic [11:0] prog [0:15] = '{12'h205, 12'h1C6, 12'h1E5, 12'h147, 12'h005, 12'h006,
		12'hE00, 12'h007, 12'h004, 12'h166, 12'h225, 12'h221, 12'h221, 12'h1C6, 12'hE00,
		12'h162};

	always #12.5 mclk = ~mclk;

	core_exec dut (.mclk(mclk), .arst_n(arst_n), .prog_addr(prog_addr),
		.prog_data(prog_data), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
		.presc_on_timer(presc_on_timer), .presc_clear(presc_clear), .acc_out(acc_out),
		.status_out(status_out), .cycle_end(cycle_end));
	pad_and_rom_model mem (.prog_addr(prog_addr), .prog_data(prog_data),
		.port_out(port_out), .port_oe(port_oe), .ext_level(ext_level), .port_in(port_in));

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// -----------------------------------------------------------
	// driver and reference model, one step per execute edge
	// -----------------------------------------------------------
	initial begin
		expect_t e;
		logic [11:0] ir, w;
		logic [7:0] a, r, y;
		logic [8:0] sum, pc;
		logic [2:0][7:0] pin;
		logic c, digit_carry_flag, z, wr, sk, br;
		int f;
		void'($urandom(32'hE6ABBADB));
		prog[6][7:0] = 8'($urandom);
		foreach (mem.rom[i]) mem.rom[i] = 12'h000;
		mem.rom[0] = 12'hB00; // far branch sets the ninth bit
		for (int i = 0; i < 16; i++) mem.rom[9'h100 + i] = prog[i];
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		arst_n = 1'b1;
		ir = 12'h000;
		pc = 9'h000;
		a = 8'h00;
		{c, digit_carry_flag, z} = 3'b000;
		e = '0;
		sk = 1'b1;
		for (int s = 0; s < 20; s++) begin
			do @(negedge mclk); while (cycle_end !== 1'b1);
			ext_level = {8'($urandom), 8'($urandom), 8'($urandom)};
			// the timer steps pin the assignment; elsewhere it must not matter
			presc_on_timer = (s == 14) ? 1'b1 : (s == 15) ? 1'b0 : 1'($urandom);
			pin = (e.oe & e.po) | (~e.oe & ext_level);
			f = ir[4:0];
			r = (f >= 5 && f <= 7) ? pin[f - 5] : 8'h00;
			wr = 1'b0;
			br = 1'b0;
			e.presc = 1'b0;
			if (ir[11:6] == 6'h07) begin
				sum = {1'b0, a} + {1'b0, r};
				y = sum[7:0];
				c = sum[8];
				digit_carry_flag = (5'(a[3:0]) + 5'(r[3:0])) > 5'h0F;
				z = (y == 8'h00);
				wr = 1'b1;
				sk = 1'b1;
			end else if (ir[11:6] == 6'h05 || ir[11:6] == 6'h08) begin
				y = (ir[11:6] == 6'h05) ? (a & r) : r;
				z = (y == 8'h00);
				wr = 1'b1;
			end else if (ir[11:8] == 4'hE) begin
				a = a & ir[7:0];
				z = (a == 8'h00);
			end else if (ir[11:3] == 9'h000 && ir[2:0] >= 3'h5) begin
				e.oe[ir[2:0] - 3'h5] = ~a;
			end
			// the timer only ever copies itself here, so it reads its reset zero
			if (wr && !ir[5])
				a = y;
			else if (wr && f >= 5 && f <= 7)
				e.po[f - 5] = y;
			else if (wr && f == 2)
				br = 1'b1;
			else if (wr && f == 1)
				e.presc = presc_on_timer;
			w = mem.rom[pc];
			if (ir[11:9] == 3'b101) begin
				pc = ir[8:0];
				ir = 12'h000;
			end else if (br) begin
				pc = {1'b0, y};
				ir = 12'h000;
			end else begin
				ir = w;
				pc = pc + 9'h001;
			end
			e.acc = a;
			e.st = {5'h00, z, digit_carry_flag, c};
			e.pc = pc;
			e.stk = sk;
			notes.push_back(e);
		end
		wait (notes.size() == 0);
		@(negedge mclk);
		conclude();
	end

	// -----------------------------------------------------------
	// monitor: one note per execute edge, read once results settle
	// -----------------------------------------------------------
	initial begin
		expect_t x;
		int gap;
		bit seen;
		gap = 0;
		seen = 1'b0;
		forever begin
			@(negedge mclk);
			gap++;
			if (cycle_end === 1'b1 && arst_n === 1'b1) begin
				if (seen) `CHK("cycle length", 4, gap)
				seen = 1'b1;
				gap = 0;
				@(negedge mclk);
				gap++;
				if (notes.size() > 0) begin
					x = notes.pop_front();
					`CHK("acc_out", x.acc, acc_out)
					if (x.stk) `CHK("status_out", x.st, status_out)
					`CHK("port_out", x.po, port_out)
					`CHK("port_oe", x.oe, port_oe)
					`CHK("prog_addr", x.pc, prog_addr)
					`CHK("presc_clear", x.presc, presc_clear)
				end
			end
		end
	end

	// about 2 us of program; ten times that means a hang
	initial begin
		#20us;
		n_mismatch++;
		conclude();
	end
endmodule
